// ===== core/ddrc_ck_gen.sv
// Memory clock divider with a command tick after each falling edge
`default_nettype none
module ddrc_ck_gen #(
    parameter int unsigned HALF = 2
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    output logic ck_out,
    output logic ck_n_out,
    output logic fall_tick_out
);
    logic [7:0] div_q;

    // Commands change one input clock after the fall, HALF - 1 input clocks before the rising edge samples them
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            div_q <= 8'h00;
            ck_out <= 1'b0;
            ck_n_out <= 1'b1;
            fall_tick_out <= 1'b0;
        end else begin
            fall_tick_out <= 1'b0;
            if (div_q == 8'(HALF - 1)) begin
                div_q <= 8'h00;
                ck_out <= !ck_out;
                ck_n_out <= ck_out;
                fall_tick_out <= ck_out; // Was high, now falls
            end else begin
                div_q <= div_q + 8'h01;
            end
        end
    end
endmodule : ddrc_ck_gen
`default_nettype wire

// ===== core/ddrc_ctrl.sv
// DDR2 command sequencer for writes, refresh, self refresh and power-down
`include "ddrc_params.svh"
`default_nettype none
module ddrc_ctrl #(
    parameter int unsigned CK_HALF = `DDRC_CK_HALF
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic act_req_in,
    input wire logic [1:0] act_bank_in,
    input wire logic [13:0] act_row_in,
    input wire logic wr_req_in,
    input wire logic [1:0] wr_bank_in,
    input wire logic [9:0] wr_col_in,
    input wire logic wr_ap_in,
    input wire logic odt_en_in,
    input wire logic pd_req_in,
    input wire logic sr_req_in,
    output logic ck_out,
    output logic ck_n_out,
    output logic cke_out,
    output logic cs_n_out,
    output logic ras_n_out,
    output logic cas_n_out,
    output logic we_n_out,
    output logic odt_out,
    output logic [1:0] ba_out,
    output logic [13:0] addr_out,
    output logic ack_out,
    output logic ready_out,
    output logic pd_out,
    output logic sr_out
);
    localparam int TRFC_CK = `DDRC_TRFC_CK;
    localparam int TCKE_CK = `DDRC_TCKE_CK;
    localparam int TAOFD_CK = `DDRC_TAOFD_CK;
    localparam int GAP_MAX = `DDRC_REF_GAP_MULT * `DDRC_TREFI_CK;
    localparam int WR_BASE = `DDRC_WL_CK + `DDRC_BL / 2 + `DDRC_TWR_CK;
    localparam int PDX_CK = (`DDRC_TXP_CK > `DDRC_TCKE_CK) ? `DDRC_TXP_CK : `DDRC_TCKE_CK;

    ddrc_pkg::ddrc_state_type state_q, state_d;
    ddrc_pkg::ddrc_cmd_type cmd_d;
    logic tick;
    logic tmr_load;
    logic [7:0] tmr_val;
    logic tmr_done;
    logic cke_d;
    logic [1:0] ba_d;
    logic [13:0] addr_d;
    logic ack_d;
    logic [3:0] open_q;
    logic [7:0] bank_rc_q [4];
    logic [7:0] refi_q;
    logic [3:0] owed_q;
    logic need_ref_q;
    logic [7:0] cke_hi_q;
    logic [7:0] cke_lo_q;
    logic [7:0] odt_lo_q;
    logic [9:0] since_ref_q;
    logic odt_block;

    // Saturating count of ticks
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == 8'hFF) ? v : v + 8'h01;
    endfunction : sat_inc

    // Command to {cs_n, ras_n, cas_n, we_n}
    function automatic logic [3:0] cmd_pins(input ddrc_pkg::ddrc_cmd_type c);
        case (c)
            ddrc_pkg::CMD_ACT: cmd_pins = `DDRC_PINS_ACT;
            ddrc_pkg::CMD_WR: cmd_pins = `DDRC_PINS_WR;
            ddrc_pkg::CMD_PRE: cmd_pins = `DDRC_PINS_PRE;
            ddrc_pkg::CMD_REF: cmd_pins = `DDRC_PINS_REF;
            ddrc_pkg::CMD_SRE: cmd_pins = `DDRC_PINS_REF;
            default: cmd_pins = `DDRC_PINS_NOP;
        endcase
    endfunction : cmd_pins

    // clock kept running
    // Clock never stops, which trades a little self refresh power for simpler exit
    ddrc_ck_gen #(.HALF(CK_HALF)) u_ck (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ck_out(ck_out),
        .ck_n_out(ck_n_out),
        .fall_tick_out(tick)
    );

    ddrc_timer #(.W(8)) u_wait (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(tick),
        .load_in(tmr_load),
        .value_in(tmr_val),
        .done_out(tmr_done)
    );

    // Next command, state and wait; refresh has first claim in idle
    always_comb begin
        state_d = state_q;
        cmd_d = ddrc_pkg::CMD_NOP;
        cke_d = cke_out;
        tmr_load = 1'b0;
        tmr_val = 8'h00;
        ba_d = ba_out;
        addr_d = addr_out;
        ack_d = 1'b0;
        case (state_q)
            ddrc_pkg::ST_IDLE: begin
                if (owed_q != 4'h0 || need_ref_q || (sr_req_in && open_q != 4'h0)) begin
                    if (open_q != 4'h0) begin
                        cmd_d = ddrc_pkg::CMD_PRE;
                        addr_d = 14'h0000;
                        addr_d[`DDRC_A10_BIT] = 1'b1;
                        tmr_load = 1'b1;
                        tmr_val = 8'(`DDRC_TRP_CK);
                        state_d = ddrc_pkg::ST_WAIT;
                    end else begin
                        cmd_d = ddrc_pkg::CMD_REF;
                        tmr_load = 1'b1;
                        tmr_val = 8'(`DDRC_TRFC_CK);
                        state_d = ddrc_pkg::ST_WAIT;
                    end
                end else if (sr_req_in) begin
                    if (odt_lo_q >= 8'(TAOFD_CK) && !odt_out && cke_hi_q >= 8'(TCKE_CK - 1)) begin
                        cmd_d = ddrc_pkg::CMD_SRE;
                        cke_d = 1'b0;
                        tmr_load = 1'b1;
                        tmr_val = 8'(`DDRC_TCKE_CK);
                        state_d = ddrc_pkg::ST_SR;
                    end
                end else if (pd_req_in) begin
                    if (cke_hi_q >= 8'(TCKE_CK - 1)) begin
                        cke_d = 1'b0;
                        tmr_load = 1'b1;
                        tmr_val = 8'(`DDRC_TCKE_CK);
                        state_d = ddrc_pkg::ST_PD;
                    end
                end else if (act_req_in && !open_q[act_bank_in] && bank_rc_q[act_bank_in] == 8'h00) begin
                    cmd_d = ddrc_pkg::CMD_ACT;
                    ba_d = act_bank_in;
                    addr_d = act_row_in;
                    ack_d = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = 8'(`DDRC_TRCD_CK);
                    state_d = ddrc_pkg::ST_WAIT;
                end else if (wr_req_in && open_q[wr_bank_in]) begin
                    // A10 selects auto-precharge; wait covers tWR, plus tRP only with auto-precharge
                    cmd_d = ddrc_pkg::CMD_WR;
                    ba_d = wr_bank_in;
                    addr_d = {3'h0, wr_ap_in, wr_col_in};
                    ack_d = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = wr_ap_in ? 8'(WR_BASE + `DDRC_TRP_CK) : 8'(WR_BASE);
                    state_d = ddrc_pkg::ST_WAIT;
                end
            end
            ddrc_pkg::ST_WAIT: begin
                if (tmr_done) begin
                    state_d = ddrc_pkg::ST_IDLE;
                end
            end
            ddrc_pkg::ST_PD: begin
                // low for tCKE; leave as soon as a refresh is owed
                if (tmr_done && (!pd_req_in || owed_q != 4'h0)) begin
                    cke_d = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = 8'(PDX_CK);
                    state_d = ddrc_pkg::ST_PD_EXIT;
                end
            end
            ddrc_pkg::ST_PD_EXIT: begin
                if (tmr_done) begin
                    state_d = ddrc_pkg::ST_IDLE;
                end
            end
            ddrc_pkg::ST_SR: begin
                if (tmr_done && !sr_req_in) begin
                    cke_d = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = 8'(`DDRC_TXSRD_CK);
                    state_d = ddrc_pkg::ST_SR_EXIT;
                end
            end
            ddrc_pkg::ST_SR_EXIT: begin
                // NOPs for the full read exit delay
                if (tmr_done) begin
                    state_d = ddrc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = ddrc_pkg::ST_IDLE;
            end
        endcase
    end

    // Pins change only on the tick after a falling clock edge
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_q <= ddrc_pkg::ST_IDLE;
            cke_out <= 1'b1;
            {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= `DDRC_PINS_NOP;
            ba_out <= 2'h0;
            addr_out <= 14'h0000;
            ack_out <= 1'b0;
        end else begin
            ack_out <= 1'b0;
            if (tick) begin
                state_q <= state_d;
                cke_out <= cke_d;
                {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= cmd_pins(cmd_d);
                ba_out <= ba_d;
                addr_out <= addr_d;
                ack_out <= ack_d;
            end
        end
    end

    // Status flags for the user side
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ready_out <= 1'b0;
            pd_out <= 1'b0;
            sr_out <= 1'b0;
        end else begin
            ready_out <= (state_q == ddrc_pkg::ST_IDLE);
            pd_out <= (state_q == ddrc_pkg::ST_PD);
            sr_out <= (state_q == ddrc_pkg::ST_SR);
        end
    end

    // termination held off around self refresh
    assign odt_block = sr_req_in || state_q == ddrc_pkg::ST_SR || state_q == ddrc_pkg::ST_SR_EXIT;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            odt_out <= 1'b0;
        end else if (tick) begin
            odt_out <= odt_en_in && !odt_block;
        end
    end

    // Open-row map and per-bank row cycle timers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            open_q <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                bank_rc_q[i] <= 8'h00;
            end
        end else if (tick) begin
            for (int i = 0; i < 4; i++) begin
                if (bank_rc_q[i] != 8'h00) begin
                    bank_rc_q[i] <= bank_rc_q[i] - 8'h01;
                end
            end
            if (cmd_d == ddrc_pkg::CMD_ACT) begin
                open_q[act_bank_in] <= 1'b1;
                bank_rc_q[act_bank_in] <= 8'(`DDRC_TRC_CK);
            end else if (cmd_d == ddrc_pkg::CMD_PRE) begin
                open_q <= 4'h0;
            end else if (cmd_d == ddrc_pkg::CMD_WR && wr_ap_in) begin
                open_q[wr_bank_in] <= 1'b0;
            end
        end
    end

    // refresh debt; self refresh clears it and restarts the interval from zero
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            refi_q <= 8'h00;
            owed_q <= 4'h0;
        end else if (tick) begin
            if (cmd_d == ddrc_pkg::CMD_SRE || state_q == ddrc_pkg::ST_SR || state_q == ddrc_pkg::ST_SR_EXIT) begin
                refi_q <= 8'h00;
                owed_q <= 4'h0;
            end else if (refi_q == 8'(`DDRC_TREFI_CK - 1)) begin
                refi_q <= 8'h00;
                // Refresh issued in the same tick cancels the new debt
                if (cmd_d != ddrc_pkg::CMD_REF && owed_q != 4'(`DDRC_REF_POST_MAX)) begin
                    owed_q <= owed_q + 4'h1;
                end
            end else begin
                refi_q <= refi_q + 8'h01;
                if (cmd_d == ddrc_pkg::CMD_REF && owed_q != 4'h0) begin
                    owed_q <= owed_q - 4'h1;
                end
            end
        end
    end

    // one extra refresh owed after each self refresh exit
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            need_ref_q <= 1'b0;
        end else if (tick) begin
            if (state_q == ddrc_pkg::ST_SR && state_d == ddrc_pkg::ST_SR_EXIT) begin
                need_ref_q <= 1'b1;
            end else if (cmd_d == ddrc_pkg::CMD_REF) begin
                need_ref_q <= 1'b0;
            end
        end
    end

    // Dwell counters for CKE levels, ODT off time and refresh spacing
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cke_hi_q <= 8'hFF;
            cke_lo_q <= 8'h00;
            odt_lo_q <= 8'hFF;
            since_ref_q <= 10'h000;
        end else if (tick) begin
            cke_hi_q <= cke_out ? sat_inc(cke_hi_q) : 8'h00;
            cke_lo_q <= cke_out ? 8'h00 : sat_inc(cke_lo_q);
            odt_lo_q <= odt_out ? 8'h00 : sat_inc(odt_lo_q);
            // Memory refreshes itself while in self refresh, so the gap restarts there
            if (cmd_d == ddrc_pkg::CMD_REF || cmd_d == ddrc_pkg::CMD_SRE ||
                    state_q == ddrc_pkg::ST_SR || state_q == ddrc_pkg::ST_SR_EXIT) begin
                since_ref_q <= 10'h000;
            end else if (since_ref_q != 10'h3FF) begin
                since_ref_q <= since_ref_q + 10'h001;
            end
        end
    end

    sequence s_sre_issue;
        tick && cmd_d == ddrc_pkg::CMD_SRE;
    endsequence

    sequence s_cke_drop;
        tick && cke_out && !cke_d;
    endsequence

    a_ref_all_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        tick && cmd_d == ddrc_pkg::CMD_REF |-> open_q == 4'h0 && tmr_done)
        else $error("refresh issued with a bank open");
    a_ref_rfc_gap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        tick && (cmd_d == ddrc_pkg::CMD_REF || cmd_d == ddrc_pkg::CMD_ACT) && since_ref_q != 10'h3FF
        |-> 32'(since_ref_q) >= TRFC_CK - 1)
        else $error("activate or refresh inside tRFC");
    a_ref_gap_max: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        32'(since_ref_q) <= GAP_MAX || since_ref_q == 10'h3FF && state_q == ddrc_pkg::ST_IDLE && $past(sys_rst_in, 2))
        else $error("refresh gap above nine intervals");
    a_sr_entry_pins: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_sre_issue |=> !cke_out && {cs_n_out, ras_n_out, cas_n_out, we_n_out} == `DDRC_PINS_REF && open_q == 4'h0)
        else $error("self refresh entry pattern wrong");
    a_sr_odt_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_sre_issue |-> !odt_out && 32'(odt_lo_q) >= TAOFD_CK)
        else $error("termination not off long enough before self refresh");
    a_sr_exit_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_q == ddrc_pkg::ST_SR_EXIT |-> cke_out && {cs_n_out, ras_n_out, cas_n_out, we_n_out} == `DDRC_PINS_NOP)
        else $error("command during self refresh exit");
    a_sr_need_ref: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_sre_issue |-> !need_ref_q && owed_q == 4'h0)
        else $error("self refresh re-entered without extra refresh");
    a_cke_low_min: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        tick && !cke_out && cke_d |-> 32'(cke_lo_q) >= TCKE_CK - 1)
        else $error("CKE low shorter than minimum");
    a_cke_high_min: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_cke_drop |-> 32'(cke_hi_q) >= TCKE_CK - 1)
        else $error("CKE high shorter than minimum");
    a_pd_entry_nop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_cke_drop and (state_q == ddrc_pkg::ST_IDLE && state_d == ddrc_pkg::ST_PD)
        |=> !cke_out && {cs_n_out, ras_n_out, cas_n_out, we_n_out} == `DDRC_PINS_NOP)
        else $error("power-down entry without NOP");
    a_wr_ap_close: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        tick && cmd_d == ddrc_pkg::CMD_WR && wr_ap_in |=> addr_out[`DDRC_A10_BIT] && !we_n_out && !tmr_done)
        else $error("write with auto-precharge lost A10");
    a_act_closed: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        tick && cmd_d == ddrc_pkg::CMD_ACT |-> !open_q[act_bank_in] && bank_rc_q[act_bank_in] == 8'h00)
        else $error("activate to a bank not yet closed");
endmodule : ddrc_ctrl
`default_nettype wire

// ===== core/ddrc_params.svh
// Timing and encoding constants for the DDR2 refresh and power-down controller
`ifndef DDRC_PARAMS_SVH
`define DDRC_PARAMS_SVH

// Controller clock and the derived memory clock
`define DDRC_CLK_NS 50
`define DDRC_CK_HALF 2
`define DDRC_TCK_NS (`DDRC_CLK_NS * 2 * `DDRC_CK_HALF)

// Minimum times round up to whole memory clocks
`define DDRC_CEIL_CK(ns) (((ns) + `DDRC_TCK_NS - 1) / `DDRC_TCK_NS)

`define DDRC_TRP_NS 15
`define DDRC_TRCD_NS 15
`define DDRC_TRC_NS 55
`define DDRC_TRFC_NS 105
`define DDRC_TWR_NS 15
`define DDRC_TREFI_NS 7800

`define DDRC_TRP_CK `DDRC_CEIL_CK(`DDRC_TRP_NS)
`define DDRC_TRCD_CK `DDRC_CEIL_CK(`DDRC_TRCD_NS)
`define DDRC_TRC_CK `DDRC_CEIL_CK(`DDRC_TRC_NS)
`define DDRC_TRFC_CK `DDRC_CEIL_CK(`DDRC_TRFC_NS)
`define DDRC_TWR_CK `DDRC_CEIL_CK(`DDRC_TWR_NS)
// Longest time: rounds down
`define DDRC_TREFI_CK (`DDRC_TREFI_NS / `DDRC_TCK_NS)

// Figures already given in memory clocks
`define DDRC_TXSRD_CK 200
`define DDRC_TCKE_CK 3
`define DDRC_TXP_CK 2
`define DDRC_TAOFD_CK 3
`define DDRC_WL_CK 2
`define DDRC_BL 4
`define DDRC_REF_POST_MAX 8
`define DDRC_REF_GAP_MULT 9

// Pin patterns {cs_n, ras_n, cas_n, we_n}
`define DDRC_PINS_NOP 4'h7
`define DDRC_PINS_ACT 4'h3
`define DDRC_PINS_WR 4'h4
`define DDRC_PINS_PRE 4'h2
`define DDRC_PINS_REF 4'h1
`define DDRC_A10_BIT 10

`endif

// ===== core/ddrc_pkg.sv
// Types shared by the DDR2 refresh and power-down controller
`default_nettype none
package ddrc_pkg;

    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_ACT = 3'h1,
        CMD_WR = 3'h2,
        CMD_PRE = 3'h3,
        CMD_REF = 3'h4,
        CMD_SRE = 3'h5
    } ddrc_cmd_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WAIT = 3'h1,
        ST_PD = 3'h2,
        ST_PD_EXIT = 3'h3,
        ST_SR = 3'h4,
        ST_SR_EXIT = 3'h5
    } ddrc_state_type;

endpackage : ddrc_pkg
`default_nettype wire

// ===== core/ddrc_timer.sv
// Down counter of memory clock ticks
`default_nettype none
module ddrc_timer #(
    parameter int unsigned W = 8
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic tick_in,
    input wire logic load_in,
    input wire logic [W-1:0] value_in,
    output logic done_out
);
    logic [W-1:0] count_q;

    // Done after value_in ticks from the loading tick
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            count_q <= '0;
        end else if (tick_in) begin
            if (load_in) begin
                count_q <= value_in;
            end else if (count_q != '0) begin
                count_q <= count_q - W'(1);
            end
        end
    end

    assign done_out = (count_q == '0);
endmodule : ddrc_timer
`default_nettype wire

// ===== sim/ddrc_mem_model.sv
// Behavioural DDR2 memory that counts illegal pin sequences
`include "ddrc_params.svh"
`default_nettype none
module ddrc_mem_model (
    input wire logic ck_in,
    input wire logic cke_in,
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic odt_in,
    input wire logic [1:0] ba_in,
    input wire logic [13:0] addr_in,
    output int err_out,
    output int ref_cnt_out,
    output int max_gap_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cmd;
    logic [3:0] open_q = '0;
    logic cke_q = 1'b1, sr_q = 1'b0, owe_q = 1'b0;
    int errs = 0, refs = 0, gap = 0, mx = 0, lo = 0, hi = 9, xs = 0, odt_lo = 9;
    assign cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
    assign err_out = errs;
    assign ref_cnt_out = refs;
    assign max_gap_out = mx;
    // Pins sampled on each rising memory clock; open rows kept in power-down
    // retention
    always @(posedge ck_in) begin
        gap = sr_q ? 0 : gap + 1;
        odt_lo = odt_in ? 0 : odt_lo + 1;
        if (gap > mx) mx = gap;
        if (cke_q && !cke_in) begin
            if (hi < 3 || (cmd == 4'h1 && (open_q != '0 || odt_lo < 3 || owe_q))) errs++;
            if (cmd != 4'h1 && cmd != 4'h7 && !cs_n_in) errs++;
            sr_q = (cmd == 4'h1);
            lo = 1;
        end else if (!cke_q && cke_in) begin
            if (lo < 3 || (!cs_n_in && cmd != 4'h7)) errs++;
            xs = sr_q ? 200 : 0;
            owe_q = owe_q | sr_q;
            sr_q = 1'b0;
            hi = 1;
        end else if (!cke_in) begin
            lo++;
            if (!sr_q && lo > `DDRC_REF_GAP_MULT * `DDRC_TREFI_CK) errs++;
        end else begin
            hi++;
            if (xs > 0) begin
                xs--;
                if (!cs_n_in && cmd != 4'h7) errs++;
            end else if (!cs_n_in) begin
                case (cmd)
                    4'h1: begin
                        if (open_q != '0) errs++;
                        open_q = '0;
                        refs++;
                        gap = 0;
                        owe_q = 1'b0;
                    end
                    4'h3: begin
                        if (open_q[ba_in]) errs++;
                        open_q[ba_in] = 1'b1;
                    end
                    4'h4: begin
                        if (!open_q[ba_in]) errs++;
                        if (addr_in[10]) open_q[ba_in] = 1'b0;
                    end
                    4'h2: open_q = addr_in[10] ? 4'h0 : open_q & ~(4'h1 << ba_in);
                    4'h7: ;
                    default: errs++;
                endcase
            end
        end
        cke_q = cke_in;
    end
endmodule : ddrc_mem_model
`default_nettype wire

// ===== sim/test_ddrc_ctrl.sv
// Self-checking bench for the DDR2 refresh and power-down controller
`include "ddrc_params.svh"
`default_nettype none
module test_ddrc_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, sys_rst_in = 1, act_req_in = 0, wr_req_in = 0, wr_ap_in = 0;
    logic odt_en_in = 0, pd_req_in = 0, sr_req_in = 0;
    logic [1:0] act_bank_in = '0, wr_bank_in = '0, ba_out;
    logic [13:0] act_row_in = '0, addr_out;
    logic [9:0] wr_col_in = '0;
    logic ck_out, ck_n_out, cke_out, cs_n_out, ras_n_out, cas_n_out, we_n_out, odt_out;
    logic ack_out, ready_out, pd_out, sr_out;
    logic [15:0] seed = 16'h1D9D;
    int bad_count = 0, samples_checked = 0, errs, refs, mx, r0;
    ddrc_ctrl ddrc_ctrl_i (.clk_in, .sys_rst_in, .act_req_in, .act_bank_in, .act_row_in, .wr_req_in,
        .wr_bank_in, .wr_col_in, .wr_ap_in, .odt_en_in, .pd_req_in, .sr_req_in, .ck_out, .ck_n_out,
        .cke_out, .cs_n_out, .ras_n_out, .cas_n_out, .we_n_out, .odt_out, .ba_out, .addr_out,
        .ack_out, .ready_out, .pd_out, .sr_out);
    ddrc_mem_model ddrc_mem_model_i (.ck_in(ck_out), .cke_in(cke_out), .cs_n_in(cs_n_out),
        .ras_n_in(ras_n_out), .cas_n_in(cas_n_out), .we_n_in(we_n_out), .odt_in(odt_out),
        .ba_in(ba_out), .addr_in(addr_out), .err_out(errs), .ref_cnt_out(refs), .max_gap_out(mx));
    // Galois-free shift register, repeatable from a fixed start
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    // Bounded wait on one status output; a hang counts as a mismatch
    task automatic wait_until(input int sel, input logic v, input string what);
        int n;
        logic s;
        for (n = 0; n < 4000; n++) begin
            @(posedge clk_in);
            #1;
            s = sel == 0 ? ack_out : sel == 1 ? pd_out : sel == 2 ? sr_out : ready_out;
            if (s === v) break;
        end
        check(what, 1, n < 4000);
    endtask : wait_until
    task automatic tally_and_finish;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    // Watchdog sized well above the expected run
    initial begin
        repeat (60000) @(posedge clk_in);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(negedge clk_in);
        check("reset pins", 7'h5D, {cke_out, cs_n_out, ras_n_out, cas_n_out, we_n_out, ck_out, ck_n_out});
        sys_rst_in = 0;
        // Random activate then write, auto-precharge drawn at random
        repeat (12) begin
            seed = lfsr(seed);
            @(negedge clk_in);
            {act_bank_in, act_row_in} = {seed[1:0], seed[15:2]};
            odt_en_in = seed[4];
            act_req_in = 1;
            wait_until(0, 1, "act ack");
            check("act pins", {4'h3, act_bank_in, act_row_in},
                {cs_n_out, ras_n_out, cas_n_out, we_n_out, ba_out, addr_out});
            @(negedge clk_in);
            seed = lfsr(seed);
            {wr_ap_in, wr_col_in} = seed[10:0];
            wr_bank_in = act_bank_in;
            wr_req_in = 1;
            // Activate stays up: a refresh may close the bank, which must reopen before the write
            do begin
                wait_until(0, 1, "wr ack");
            end while (we_n_out !== 1'b0 && bad_count == 0);
            check("wr pins", {4'h4, act_bank_in, 3'h0, wr_ap_in, wr_col_in},
                {cs_n_out, ras_n_out, cas_n_out, we_n_out, ba_out, addr_out});
            @(negedge clk_in);
            act_req_in = 0;
            wr_req_in = 0;
        end
        pd_req_in = 1;
        wait_until(1, 1, "pd entry");
        check("pd pins", 5'h07, {cke_out, cs_n_out, ras_n_out, cas_n_out, we_n_out});
        wait_until(1, 0, "pd exit");
        @(negedge clk_in);
        pd_req_in = 0;
        odt_en_in = 1;
        sr_req_in = 1;
        wait_until(2, 1, "sr entry");
        check("sr pins", 6'h01, {odt_out, cke_out, cs_n_out, ras_n_out, cas_n_out, we_n_out});
        repeat (1600) @(negedge clk_in);
        check("sr hold", 1, sr_out);
        r0 = refs;
        sr_req_in = 0;
        wait_until(3, 1, "sr exit");
        repeat (12) @(negedge clk_in);
        check("extra ref", 1, refs > r0);
        r0 = refs;
        repeat (4000) @(negedge clk_in);
        check("ref rate", 1, refs - r0 >= 4000 / (2 * `DDRC_CK_HALF * `DDRC_TREFI_CK) - 1);
        check("ref gap", 1, mx <= `DDRC_REF_GAP_MULT * `DDRC_TREFI_CK);
        check("mem errors", 0, errs);
        tally_and_finish();
    end
endmodule : test_ddrc_ctrl
`default_nettype wire
